// ### fbdac_cfg.svh
`ifndef FBDAC_CFG_SVH
`define FBDAC_CFG_SVH

// register addresses on the plain port
`define FBDAC_ADDR_W        8
`define FBDAC_CTRL_ADDR     8'h00
`define FBDAC_LEVEL_ADDR    8'h01
`define FBDAC_AUX_ADDR      8'h02

// control register fields
`define FBDAC_EN_BIT        7
`define FBDAC_PIN1_BIT      5
`define FBDAC_PIN2_BIT      4
`define FBDAC_PSS_HI        3
`define FBDAC_PSS_LO        2
`define FBDAC_NSS_BIT       0

// aux register fields
`define FBDAC_LPS_BIT       0

// writable masks, unimplemented bits stay zero
`define FBDAC_CTRL_MASK     8'hbd
`define FBDAC_LEVEL_MASK    8'h1f
`define FBDAC_AUX_MASK      8'h01

// reset values
`define FBDAC_CTRL_RST      8'h00
`define FBDAC_LEVEL_RST     8'h00
`define FBDAC_AUX_RST       8'h00

// level code extremes
`define FBDAC_CODE_TOP      5'h1f
`define FBDAC_CODE_BOT      5'h00

`endif

// ### fbdac_pkg.sv
package fbdac_pkg;

  // positive source encoding, order matches the two-bit field
  typedef enum logic [1:0] {
    PSRC_SUPPLY,
    PSRC_EXT_REF,
    PSRC_FIXED_REF,
    PSRC_RESERVED
  } fbdac_psrc_t;

endpackage

// ### fbdac_sync.sv
`timescale 1ns/10ps

module fbdac_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ### fbdac_pin.sv
`timescale 1ns/10ps

module fbdac_pin (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic route,
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  input  wire logic pad_sync,
  output logic      drv_out,
  output logic      drv_oe,
  output logic      ibuf_en,
  output logic      read_val
);

  // analog route takes the pad away from the digital port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_out  <= 1'b0;
      drv_oe   <= 1'b0;
      ibuf_en  <= 1'b1;
      read_val <= 1'b0;
    end else begin
      drv_out  <= route ? 1'b0 : gpio_out;
      drv_oe   <= route ? 1'b0 : gpio_oe; // [RULE6]
      ibuf_en  <= !route; // [RULE6]
      read_val <= route ? 1'b0 : pad_sync; // [RULE7]
    end
  end

endmodule

// ### fbdac_top.sv
// Contract
// [RULE1] enable bit seven switches converter on
// [RULE2] five-bit level code picks 32 levels
// [RULE3] enabled output is scaled code on ladder
// [RULE4] off, low-power, all ones gives positive
// [RULE5] bits five and four route pins
// [RULE6] routed pin loses driver and input
// [RULE7] routed pin always reads zero
// [RULE8] positive source field, 11 reserved
// [RULE9] bit zero picks negative source
// [RULE10] wake from sleep keeps control register
// [RULE11] software disables converter before sleep
// [RULE12] reset disables, unroutes, clears level
// [RULE13] implemented bits reset to zero
// [RULE14] unimplemented bits read as zero
// [RULE15] writes to unimplemented bits ignored
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "fbdac_cfg.svh"

module fbdac_top #(
  parameter int LEVEL_W = 5
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       wake_from_sleep,
  input  wire logic       pin1_gpio_out,
  input  wire logic       pin1_gpio_oe,
  input  wire logic       pin1_pad_in,
  input  wire logic       pin2_gpio_out,
  input  wire logic       pin2_gpio_oe,
  input  wire logic       pin2_pad_in,
  output logic            pin1_drv_out,
  output logic            pin1_drv_oe,
  output logic            pin1_ibuf_en,
  output logic            pin1_read,
  output logic            pin2_drv_out,
  output logic            pin2_drv_oe,
  output logic            pin2_ibuf_en,
  output logic            pin2_read,
  output logic            converter_on,
  output logic            level_out_pin1,
  output logic            level_out_pin2,
  output logic [LEVEL_W-1:0] ladder_tap,
  output logic            ladder_connect,
  output logic            tie_to_positive,
  output logic            tie_to_negative,
  output logic            psrc_supply,
  output logic            psrc_ext_ref,
  output logic            psrc_fixed_reference,
  output logic            nsrc_ext_ref,
  output logic            nsrc_ground
);

  ////////////////////////////////////////////////////////////////////////
  // parameter check

  if (LEVEL_W < 1 || LEVEL_W > 5) begin : g_bad_width
    $error("level width must lie between 1 and 5");
  end

  ////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] ref_converter_control;
  logic [7:0] ref_converter_level;
  logic [7:0] aux_control;

  logic       wr_ctrl;
  logic       wr_level;
  logic       wr_aux;

  assign wr_ctrl  = reg_wr && reg_addr == `FBDAC_CTRL_ADDR;
  assign wr_level = reg_wr && reg_addr == `FBDAC_LEVEL_ADDR;
  assign wr_aux   = reg_wr && reg_addr == `FBDAC_AUX_ADDR;

  // wake has no path into this register, it simply holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_converter_control <= `FBDAC_CTRL_RST; // [RULE12] [RULE13]
    end else if (wr_ctrl) begin // [RULE10]
      ref_converter_control <= reg_wdata & `FBDAC_CTRL_MASK; // [RULE15]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_converter_level <= `FBDAC_LEVEL_RST; // [RULE12] [RULE13]
    end else if (wr_level) begin
      ref_converter_level <= reg_wdata & `FBDAC_LEVEL_MASK; // [RULE15]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_control <= `FBDAC_AUX_RST;
    end else if (wr_aux) begin
      aux_control <= reg_wdata & `FBDAC_AUX_MASK;
    end
  end

  // stored bits are already masked, so reads give zero in every unimplemented bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `FBDAC_CTRL_ADDR:  reg_rdata <= ref_converter_control; // [RULE14]
        `FBDAC_LEVEL_ADDR: reg_rdata <= ref_converter_level; // [RULE14]
        `FBDAC_AUX_ADDR:   reg_rdata <= aux_control;
        default:           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field views

  logic               en_bit;
  logic               pin1_bit;
  logic               pin2_bit;
  logic               nss_bit;
  logic               lps_bit;
  logic [LEVEL_W-1:0] level_code;
  fbdac_pkg::fbdac_psrc_t positive_source_select;

  assign en_bit     = ref_converter_control[`FBDAC_EN_BIT];
  assign pin1_bit   = ref_converter_control[`FBDAC_PIN1_BIT];
  assign pin2_bit   = ref_converter_control[`FBDAC_PIN2_BIT];
  assign nss_bit    = ref_converter_control[`FBDAC_NSS_BIT];
  assign lps_bit    = aux_control[`FBDAC_LPS_BIT];
  assign level_code = ref_converter_level[LEVEL_W-1:0];
  assign positive_source_select = fbdac_pkg::fbdac_psrc_t'(
    ref_converter_control[`FBDAC_PSS_HI:`FBDAC_PSS_LO]);

  logic code_top;
  logic code_bot;

  assign code_top = level_code == LEVEL_W'(`FBDAC_CODE_TOP);
  assign code_bot = level_code == LEVEL_W'(`FBDAC_CODE_BOT);

  ////////////////////////////////////////////////////////////////////////
  // ladder control

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_on   <= 1'b0;
      ladder_connect <= 1'b0;
    end else begin
      converter_on   <= en_bit; // [RULE1]
      ladder_connect <= en_bit; // [RULE1]
    end
  end

  // tap is the code itself: out = neg + span * code / 2^5
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ladder_tap <= '0;
    end else begin
      ladder_tap <= level_code; // [RULE2] [RULE3]
    end
  end

  // with the ladder off only the two end codes tie the output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tie_to_positive <= 1'b0;
      tie_to_negative <= 1'b0;
    end else begin
      tie_to_positive <= !en_bit && lps_bit && code_top; // [RULE4]
      tie_to_negative <= !en_bit && !lps_bit && code_bot;
    end
  end

  // reserved code selects no source, the ladder top floats
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psrc_supply          <= 1'b0;
      psrc_ext_ref         <= 1'b0;
      psrc_fixed_reference <= 1'b0;
    end else begin
      psrc_supply          <= 1'b0;
      psrc_ext_ref         <= 1'b0;
      psrc_fixed_reference <= 1'b0;
      case (positive_source_select)
        fbdac_pkg::PSRC_SUPPLY:    psrc_supply <= 1'b1; // [RULE8]
        fbdac_pkg::PSRC_EXT_REF:   psrc_ext_ref <= 1'b1; // [RULE8]
        fbdac_pkg::PSRC_FIXED_REF: psrc_fixed_reference <= 1'b1; // [RULE8]
        default:                   psrc_supply <= 1'b0;
      endcase
    end
  end

  // ground is the safe default after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nsrc_ext_ref <= 1'b0;
      nsrc_ground  <= 1'b1;
    end else begin
      nsrc_ext_ref <= nss_bit; // [RULE9]
      nsrc_ground  <= !nss_bit; // [RULE9]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin routing and override

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_out_pin1 <= 1'b0; // [RULE12]
      level_out_pin2 <= 1'b0; // [RULE12]
    end else begin
      level_out_pin1 <= pin1_bit; // [RULE5]
      level_out_pin2 <= pin2_bit; // [RULE5]
    end
  end

  logic [1:0] pad_sync;

  fbdac_sync #(
    .W (2)
  ) u_pad_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({pin2_pad_in, pin1_pad_in}),
    .q     (pad_sync)
  );

  // driver off, input detector off, read forced low
  fbdac_pin u_pin1 ( // [RULE6] [RULE7]
    .clk      (clk),
    .rst_n    (rst_n),
    .route    (pin1_bit),
    .gpio_out (pin1_gpio_out),
    .gpio_oe  (pin1_gpio_oe),
    .pad_sync (pad_sync[0]),
    .drv_out  (pin1_drv_out),
    .drv_oe   (pin1_drv_oe),
    .ibuf_en  (pin1_ibuf_en),
    .read_val (pin1_read)
  );

  fbdac_pin u_pin2 ( // [RULE6] [RULE7]
    .clk      (clk),
    .rst_n    (rst_n),
    .route    (pin2_bit),
    .gpio_out (pin2_gpio_out),
    .gpio_oe  (pin2_gpio_oe),
    .pad_sync (pad_sync[1]),
    .drv_out  (pin2_drv_out),
    .drv_oe   (pin2_drv_oe),
    .ibuf_en  (pin2_ibuf_en),
    .read_val (pin2_read)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_ctrl_write;
    wr_ctrl ##1 1'b1;
  endsequence

  sequence s_off_top;
    !en_bit && lps_bit && code_top;
  endsequence

  sequence s_routed_pin1;
    pin1_bit ##1 pin1_bit;
  endsequence

  chk_enable_follow: assert property ( // [RULE1]
    reg_wr && reg_addr == `FBDAC_CTRL_ADDR
    |=> ##1 converter_on == $past(reg_wdata[`FBDAC_EN_BIT], 2)
        && ladder_connect == converter_on)
    else $error("converter enable did not follow control write");

  chk_tap_code: assert property ( // [RULE2] [RULE3]
    wr_level |=> ##1 ladder_tap == $past(reg_wdata[LEVEL_W-1:0], 2))
    else $error("ladder tap differs from written level code");

  chk_tie_pos: assert property ( // [RULE4]
    s_off_top |=> tie_to_positive && !ladder_connect)
    else $error("disabled all-ones code did not tie to positive");

  chk_route_pins: assert property ( // [RULE5]
    s_ctrl_write |=> level_out_pin1 == $past(reg_wdata[`FBDAC_PIN1_BIT], 2)
        && level_out_pin2 == $past(reg_wdata[`FBDAC_PIN2_BIT], 2))
    else $error("pin route does not match control write");

  chk_pin_driver_off: assert property ( // [RULE6]
    s_routed_pin1 |-> !pin1_drv_oe && !pin1_ibuf_en)
    else $error("routed pin still drives or senses");

  chk_pin_read_zero: assert property ( // [RULE7]
    pin2_bit ##1 pin2_bit |-> !pin2_read)
    else $error("routed pin read returned one");

  chk_pos_select: assert property ( // [RULE8]
    positive_source_select == fbdac_pkg::PSRC_RESERVED
    |=> !psrc_supply && !psrc_ext_ref && !psrc_fixed_reference)
    else $error("reserved positive source selected a rail");

  chk_neg_select: assert property ( // [RULE9]
    nss_bit |=> nsrc_ext_ref && !nsrc_ground)
    else $error("negative source not on external pin");

  chk_wake_hold: assert property ( // [RULE10]
    wake_from_sleep && !wr_ctrl |=> $stable(ref_converter_control))
    else $error("control register changed on wake");

  chk_unimpl_read: assert property ( // [RULE14]
    reg_rd && reg_addr == `FBDAC_LEVEL_ADDR |=> reg_rdata[7:5] == 3'h0)
    else $error("unimplemented level bits read nonzero");

  chk_ctrl_unimpl: assert property ( // [RULE14]
    reg_rd && reg_addr == `FBDAC_CTRL_ADDR
    |=> !reg_rdata[6] && !reg_rdata[1])
    else $error("unimplemented control bits read nonzero");

  // checked only while reset is held, so the default disable is lifted
  chk_reset_clear: assert property ( // [RULE12]
    disable iff (1'b0)
    !rst_n ##1 !rst_n |-> !converter_on && !level_out_pin1
        && !level_out_pin2 && ladder_tap == '0)
    else $error("reset left converter on, routed or coded");

  chk_level_mask: assert property ( // [RULE15]
    wr_level |=> ref_converter_level
                 == ($past(reg_wdata) & `FBDAC_LEVEL_MASK))
    else $error("level write touched unimplemented bits");

  chk_write_mask: assert property ( // [RULE15]
    wr_ctrl |=> ref_converter_control
                == ($past(reg_wdata) & `FBDAC_CTRL_MASK))
    else $error("control write touched unimplemented bits");

endmodule

// ### fbdac_top_test.sv
`timescale 1ns/10ps
`include "fbdac_cfg.svh"

module fbdac_top_test;
  logic       clk, rst_n, reg_wr, reg_rd, wake_from_sleep;
  logic       rd_pend = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ctrl;
  logic [4:0] ladder_tap, code;
  logic [1:0] gpio_out, gpio_oe, pad_in, drv_out, drv_oe, ibuf_en, pin_rd;
  logic       converter_on, level_out_pin1, level_out_pin2, ladder_connect;
  logic       tie_to_positive, tie_to_negative, psrc_supply, psrc_ext_ref;
  logic       psrc_fixed_reference, nsrc_ext_ref, nsrc_ground, lps, en;
  logic [7:0] exp_q[$];
  int         miscompares = 0;
  int         num_checks = 0;

  fbdac_top dut (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .wake_from_sleep, .converter_on, .level_out_pin1, .level_out_pin2,
    .ladder_tap, .ladder_connect, .tie_to_positive, .tie_to_negative,
    .psrc_supply, .psrc_ext_ref, .psrc_fixed_reference, .nsrc_ext_ref,
    .nsrc_ground,
    .pin1_gpio_out(gpio_out[0]), .pin1_gpio_oe(gpio_oe[0]),
    .pin1_pad_in(pad_in[0]), .pin2_gpio_out(gpio_out[1]),
    .pin2_gpio_oe(gpio_oe[1]), .pin2_pad_in(pad_in[1]),
    .pin1_drv_out(drv_out[0]), .pin1_drv_oe(drv_oe[0]),
    .pin1_ibuf_en(ibuf_en[0]), .pin1_read(pin_rd[0]),
    .pin2_drv_out(drv_out[1]), .pin2_drv_oe(drv_oe[1]),
    .pin2_ibuf_en(ibuf_en[1]), .pin2_read(pin_rd[1])
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // expected data is queued at request time, judged by the monitor
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic rst_chk();
    check("rst_out", {converter_on, ladder_connect, level_out_pin1,
      level_out_pin2, tie_to_positive, tie_to_negative, nsrc_ext_ref,
      nsrc_ground}, 8'h01);
    check("rst_pin", {drv_out, drv_oe, ibuf_en, pin_rd}, 8'h0c);
    check("rst_tap", {psrc_supply, psrc_ext_ref, psrc_fixed_reference,
      ladder_tap}, 8'h00);
  endtask

  task automatic regs_zero();
    rd(`FBDAC_CTRL_ADDR, 8'h00);
    rd(`FBDAC_LEVEL_ADDR, 8'h00);
    rd(`FBDAC_AUX_ADDR, 8'h00);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_pend && exp_q.size() > 0)
      check("rdata", reg_rdata, exp_q.pop_front());
    rd_pend = reg_rd;
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, wake_from_sleep} = 3'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    {gpio_out, gpio_oe, pad_in} = 6'h00;
    void'($urandom(32'h4a4e));
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_chk();
    @(posedge clk);
    rst_n <= 1'b1;
    regs_zero();
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      gpio_out <= 2'($urandom());
      gpio_oe <= 2'($urandom());
      pad_in <= 2'($urandom());
      ctrl = 8'($urandom());
      ctrl[3:2] = 2'(i);
      ctrl[7] = 1'(i >> 2);
      code = (i % 4 == 0) ? 5'h1f : (i % 4 == 1) ? 5'h00 : 5'($urandom());
      lps = 1'($urandom());
      en = ctrl[7];
      // unimplemented bits are written with noise on purpose
      wr(`FBDAC_CTRL_ADDR, ctrl);
      wr(`FBDAC_LEVEL_ADDR, {3'($urandom()), code});
      wr(`FBDAC_AUX_ADDR, {7'($urandom()), lps});
      rd(`FBDAC_CTRL_ADDR, ctrl & `FBDAC_CTRL_MASK);
      rd(`FBDAC_LEVEL_ADDR, {3'h0, code});
      @(posedge clk);
      @(negedge clk);
      check("on", {6'h0, converter_on, ladder_connect},
        {6'h0, en, en});
      check("tap", {3'h0, ladder_tap}, {3'h0, code});
      check("tie", {6'h0, tie_to_positive, tie_to_negative},
        {6'h0, !en && lps && code == 5'h1f,
         !en && !lps && code == 5'h00});
      check("src", {3'h0, psrc_supply, psrc_ext_ref, psrc_fixed_reference,
        nsrc_ext_ref, nsrc_ground}, {3'h0, ctrl[3:2] == 2'h0,
        ctrl[3:2] == 2'h1, ctrl[3:2] == 2'h2, ctrl[0],
        !ctrl[0]});
      check("route", {6'h0, level_out_pin1, level_out_pin2},
        {6'h0, ctrl[5:4]});
      for (int j = 0; j < 2; j++)
        check("pin", {4'h0, drv_out[j], drv_oe[j], ibuf_en[j], pin_rd[j]},
          ctrl[5 - j] ? 8'h00 : {4'h0, gpio_out[j], gpio_oe[j], 1'b1,
          pad_in[j]});
    end
    // unmapped address: write dropped, reads as zero
    wr(`FBDAC_CTRL_ADDR, 8'hb5);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h00);
    rd(`FBDAC_CTRL_ADDR, 8'hb5);
    // converter switched off ahead of sleep to save current
    wr(`FBDAC_CTRL_ADDR, 8'h35);
    @(posedge clk);
    wake_from_sleep <= 1'b1;
    @(posedge clk);
    wake_from_sleep <= 1'b0;
    rd(`FBDAC_CTRL_ADDR, 8'h35);
    @(negedge clk);
    check("wake_on", {7'h0, converter_on}, 8'h00);
    check("wake_route", {6'h0, level_out_pin1, level_out_pin2},
      8'h03);
    // second reset in mid-run with pins routed, converter off and level at all ones
    wr(`FBDAC_LEVEL_ADDR, 8'h1f);
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    rst_chk();
    @(posedge clk);
    rst_n <= 1'b1;
    regs_zero();
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule
